// ---- tslp_pkg.sv ----
// shared constants for the tributary service level parser and its controller
// assumes byte-wide supervisory message blocks with an end-of-block marker
package tslp_pkg;

	////////////////////////////////////////////////////////////////////////
	// keywords: plain defaults, adjust to the system message set
	localparam logic [7:0] KW_SEG_INIT = 8'h01;
	localparam logic [7:0] KW_SEG_SUB = 8'h02;
	localparam logic [7:0] KW_BLOCK = 8'h03;
	localparam logic [7:0] KW_VM_SELECT = 8'h04;
	localparam logic [7:0] KW_GRP_ASSIGN = 8'h05;
	localparam logic [7:0] KW_GRP_DEASSIGN = 8'h06;
	localparam logic [7:0] KW_GRP_SELECT = 8'h07;
	localparam logic [7:0] KW_SL_RESET = 8'h08;

	////////////////////////////////////////////////////////////////////////
	// block and segment geometry
	localparam int MAX_BLOCK_BYTES = 256;
	localparam int SEG_HDR_BYTES = 2;
	localparam int SEG_DATA_MAX = MAX_BLOCK_BYTES - SEG_HDR_BYTES;
	localparam logic [7:0] FINAL_SEG_COUNT = 8'h00;
	localparam int REASM_DEPTH = 4096;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [7:0] RESET_VM = 8'h00;

endpackage

// ---- tslp_link_if.sv ----
// byte link between bus controller and tributary service level
// assumes the testbench clocks both ends from the same core_clk
`timescale 1ns/1ps
interface tslp_link_if;
	logic dn_valid;
	logic dn_ready;
	logic [7:0] dn_data;
	logic dn_last;
	logic up_valid;
	logic up_ready;
	logic [7:0] up_data;
	logic up_last;

	modport trib (
		input dn_valid,
		output dn_ready,
		input dn_data,
		input dn_last,
		output up_valid,
		input up_ready,
		output up_data,
		output up_last
	);

	modport ctrl (
		output dn_valid,
		input dn_ready,
		output dn_data,
		output dn_last,
		input up_valid,
		output up_ready,
		input up_data,
		input up_last
	);
endinterface

// ---- tslp_ctrl.sv ----
// bus controller end: frames messages, segments long ones, sends selects
// assumes msg_len and msg_vm stay steady for a whole message
//
// Summary of operation
// - segments open with initial or subsequent keyword
// - second byte counts remaining segments, final zero
// - nothing follows a segment within its block
// - block is keyword, count, then count bytes
// - block count byte delimits block data
// - block data forwarded unchanged until consumed
// - unknown keyword: message forwarded unparsed
// - nonzero count segment stored, await next
// - final segment releases whole reassembly unchanged
// - end of supervisory block returns to keyword
// - virtual machine route held until reselected
// - controller selects before messages to other machine
// - machine emitting message after another machine gets reverse select sent
// - group commands add or remove machines
// - reset: machine zero, errors, reassembly, groups cleared
// - blocks hold 1 to 256 bytes
`timescale 1ns/1ps
module tslp_ctrl #(
	parameter int VM_W = 4,
	parameter int SEG_MAX = tslp_pkg::SEG_DATA_MAX
) (
	input logic core_clk,
	input logic rst_n,
	tslp_link_if.ctrl link,
	input logic msg_valid,
	output logic msg_ready,
	input logic [VM_W-1:0] msg_vm,
	input logic [15:0] msg_len,
	input logic [7:0] msg_data,
	input logic msg_last,
	input logic cmd_valid,
	output logic cmd_ready,
	input logic [7:0] cmd_code,
	input logic [7:0] cmd_arg,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic [VM_W-1:0] rx_vm
);

	typedef enum logic [2:0] {C_IDLE, C_SEL_KEY, C_SEL_ARG, C_CMD_KEY,
		C_CMD_ARG, C_SEG_KEY, C_SEG_CNT, C_DATA} tslp_cst_t;

	if (VM_W < 1 || VM_W > 8) begin : g_bad_vm
		$error("VM_W must be 1 to 8");
	end
	if (SEG_MAX < 1 || SEG_MAX > tslp_pkg::SEG_DATA_MAX) begin : g_bad_seg
		$error("SEG_MAX must fit one block with its header");
	end

	function automatic logic [7:0] segs_after(input logic [15:0] len);
		logic [15:0] n;
		n = 16'((32'(len) + SEG_MAX - 1) / SEG_MAX);
		segs_after = 8'(n - 16'h0001);
	endfunction

	tslp_cst_t st_reg;
	logic [VM_W-1:0] cur_vm_reg;
	logic vm_known_reg;
	logic seg_mode_reg;
	logic seg_first_reg;
	logic [7:0] seg_left_reg;
	logic [7:0] chunk_reg;
	logic [7:0] cmd_code_reg;
	logic [7:0] cmd_arg_reg;
	logic chunk_end;
	logic is_reset_cmd;
	logic up_first_reg;
	logic up_sel_reg;

	assign chunk_end = seg_mode_reg && (chunk_reg == 8'(SEG_MAX - 1));
	assign is_reset_cmd = (cmd_code_reg == tslp_pkg::KW_SL_RESET);

	////////////////////////////////////////////////////////////////////////
	// link drive
	assign cmd_ready = (st_reg == C_IDLE);
	assign msg_ready = (st_reg == C_DATA) && link.dn_ready;
	assign link.dn_valid = (st_reg == C_DATA) ? msg_valid : (st_reg != C_IDLE);
	always_comb begin
		case (st_reg)
			C_SEL_KEY: link.dn_data = tslp_pkg::KW_VM_SELECT;
			C_SEL_ARG: link.dn_data = 8'(cur_vm_reg);
			C_CMD_KEY: link.dn_data = cmd_code_reg;
			C_CMD_ARG: link.dn_data = cmd_arg_reg;
			C_SEG_KEY: link.dn_data = seg_first_reg ? tslp_pkg::KW_SEG_INIT :
				tslp_pkg::KW_SEG_SUB;
			C_SEG_CNT: link.dn_data = seg_left_reg;
			C_DATA: link.dn_data = msg_data;
			default: link.dn_data = 8'h00;
		endcase
	end
	// a segment always closes its block, nothing rides behind it
	assign link.dn_last = (st_reg == C_SEL_ARG) || (st_reg == C_CMD_ARG) ||
		((st_reg == C_CMD_KEY) && is_reset_cmd) ||
		((st_reg == C_DATA) && (msg_last || chunk_end));

	////////////////////////////////////////////////////////////////////////
	// framing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= C_IDLE;
			cur_vm_reg <= VM_W'(tslp_pkg::RESET_VM);
			vm_known_reg <= 1'b1;
			seg_mode_reg <= 1'b0;
			seg_first_reg <= 1'b0;
			seg_left_reg <= 8'h00;
			chunk_reg <= 8'h00;
			cmd_code_reg <= 8'h00;
			cmd_arg_reg <= 8'h00;
		end else begin
			case (st_reg)
				C_IDLE: begin
					if (cmd_valid) begin
						cmd_code_reg <= cmd_code;
						cmd_arg_reg <= cmd_arg;
						st_reg <= C_CMD_KEY;
					end else if (msg_valid) begin
						// long messages are split into segments
						seg_mode_reg <= (msg_len > 16'(tslp_pkg::MAX_BLOCK_BYTES));
						seg_first_reg <= 1'b1;
						seg_left_reg <= segs_after(msg_len);
						chunk_reg <= 8'h00;
						if (!vm_known_reg || msg_vm != cur_vm_reg) begin
							cur_vm_reg <= msg_vm;
							vm_known_reg <= 1'b1;
							st_reg <= C_SEL_KEY;
						end else if (msg_len > 16'(tslp_pkg::MAX_BLOCK_BYTES)) begin
							st_reg <= C_SEG_KEY;
						end else begin
							st_reg <= C_DATA;
						end
					end
				end
				C_SEL_KEY: begin
					if (link.dn_ready) begin
						st_reg <= C_SEL_ARG;
					end
				end
				C_SEL_ARG: begin
					if (link.dn_ready) begin
						st_reg <= seg_mode_reg ? C_SEG_KEY : C_DATA;
					end
				end
				C_CMD_KEY: begin
					if (link.dn_ready) begin
						if (is_reset_cmd) begin
							cur_vm_reg <= VM_W'(tslp_pkg::RESET_VM);
							vm_known_reg <= 1'b1;
							st_reg <= C_IDLE;
						end else begin
							st_reg <= C_CMD_ARG;
						end
					end
				end
				C_CMD_ARG: begin
					if (link.dn_ready) begin
						if (cmd_code_reg == tslp_pkg::KW_VM_SELECT) begin
							cur_vm_reg <= cmd_arg_reg[VM_W-1:0];
							vm_known_reg <= 1'b1;
						end else if (cmd_code_reg == tslp_pkg::KW_GRP_SELECT) begin
							vm_known_reg <= 1'b0;
						end
						st_reg <= C_IDLE;
					end
				end
				C_SEG_KEY: begin
					if (link.dn_ready) begin
						st_reg <= C_SEG_CNT;
					end
				end
				C_SEG_CNT: begin
					if (link.dn_ready) begin
						chunk_reg <= 8'h00;
						st_reg <= C_DATA;
					end
				end
				C_DATA: begin
					if (msg_valid && link.dn_ready) begin
						chunk_reg <= chunk_reg + 8'h01;
						if (msg_last) begin
							st_reg <= C_IDLE;
						end else if (chunk_end) begin
							seg_first_reg <= 1'b0;
							seg_left_reg <= seg_left_reg - 8'h01;
							st_reg <= C_SEG_KEY;
						end
					end
				end
				default: st_reg <= C_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reverse path: select messages retag, everything else goes up
	assign link.up_ready = 1'b1;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_first_reg <= 1'b1;
			up_sel_reg <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_last <= 1'b0;
			rx_vm <= VM_W'(tslp_pkg::RESET_VM);
		end else begin
			rx_valid <= 1'b0;
			if (link.up_valid) begin
				up_first_reg <= link.up_last;
				if (up_first_reg && link.up_data == tslp_pkg::KW_VM_SELECT) begin
					up_sel_reg <= 1'b1;
				end else if (up_sel_reg) begin
					rx_vm <= link.up_data[VM_W-1:0];
					up_sel_reg <= 1'b0;
				end else begin
					rx_valid <= 1'b1;
					rx_data <= link.up_data;
					rx_last <= link.up_last;
				end
			end
		end
	end

endmodule // tslp_ctrl

// ---- tslp_trib.sv ----
// tributary end: parses service level messages from the bus controller
// assumes one byte per cycle at most and dn_last on each block's last byte
`timescale 1ns/1ps
module tslp_trib #(
	parameter int VM_W = 4,
	parameter int BUF_DEPTH = tslp_pkg::REASM_DEPTH
) (
	input logic core_clk,
	input logic rst_n,
	tslp_link_if.trib link,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	output logic [2**VM_W-1:0] out_vm_mask,
	output logic [VM_W-1:0] selected_vm,
	output logic seq_error,
	input logic vm_tx_valid,
	output logic vm_tx_ready,
	input logic [VM_W-1:0] vm_tx_vm,
	input logic [7:0] vm_tx_data,
	input logic vm_tx_last
);

	localparam int PTR_W = $clog2(BUF_DEPTH) + 1;

	typedef enum logic [3:0] {S_KEY, S_PASS, S_BLK_CNT, S_BLK_DATA,
		S_SEG_CNT, S_SEG_DATA, S_ARG, S_SKIP, S_DRAIN} tslp_st_t;
	typedef enum logic [1:0] {T_IDLE, T_SEL_KEY, T_SEL_ARG, T_MSG} tslp_tst_t;

	if (VM_W < 1 || VM_W > 8) begin : g_bad_vm
		$error("VM_W must be 1 to 8");
	end
	if (BUF_DEPTH < 2) begin : g_bad_depth
		$error("BUF_DEPTH must be at least 2");
	end

	tslp_st_t st_reg;
	tslp_st_t st_next;
	tslp_tst_t tx_st_reg;
	logic [7:0] seg_mem [BUF_DEPTH];
	logic [PTR_W-1:0] wptr_reg;
	logic [PTR_W-1:0] rptr_reg;
	logic [7:0] seg_cnt_reg;
	logic [7:0] blk_cnt_reg;
	logic [7:0] cmd_reg;
	logic seg_sub_reg;
	logic seg_active_reg;
	logic seq_error_reg;
	logic [VM_W-1:0] sel_vm_reg;
	logic group_mode_reg;
	logic [2**VM_W-1:0] group_mask_reg;
	logic [VM_W-1:0] rev_vm_reg;
	logic rev_valid_reg;
	logic take;
	logic seg_bad;
	logic buf_full;
	logic drain_end;
	logic sl_reset;
	logic [7:0] d;

	assign d = link.dn_data;
	// link stalls while the reassembly drains; no second buffer needed
	assign link.dn_ready = (st_reg != S_DRAIN);
	assign take = link.dn_valid && link.dn_ready;
	assign buf_full = (wptr_reg == PTR_W'(BUF_DEPTH));
	assign seg_bad = seg_sub_reg &&
		(!seg_active_reg || d != seg_cnt_reg - 8'h01);
	assign drain_end = (wptr_reg == '0) || (rptr_reg == wptr_reg - 1'b1);
	assign sl_reset = take && (st_reg == S_KEY) && (d == tslp_pkg::KW_SL_RESET);
	assign seq_error = seq_error_reg;
	assign selected_vm = sel_vm_reg;
	// a single virtual group per tributary keeps the switch small
	assign out_vm_mask = group_mode_reg ? group_mask_reg :
		(2**VM_W)'(1) << sel_vm_reg;

	////////////////////////////////////////////////////////////////////////
	// parser state
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			S_KEY: begin
				if (take) begin
					case (d)
						tslp_pkg::KW_BLOCK: st_next = S_BLK_CNT;
						tslp_pkg::KW_SEG_INIT, tslp_pkg::KW_SEG_SUB:
							st_next = S_SEG_CNT;
						tslp_pkg::KW_VM_SELECT, tslp_pkg::KW_GRP_ASSIGN,
						tslp_pkg::KW_GRP_DEASSIGN, tslp_pkg::KW_GRP_SELECT:
							st_next = S_ARG;
						tslp_pkg::KW_SL_RESET: st_next = S_KEY;
						default: st_next = S_PASS;
					endcase
				end
			end
			S_BLK_CNT: begin
				if (take) begin
					st_next = (d == 8'h00) ? S_KEY : S_BLK_DATA;
				end
			end
			S_BLK_DATA: begin
				if (take && blk_cnt_reg == 8'h01) begin
					st_next = S_KEY;
				end
			end
			S_SEG_CNT: begin
				if (take) begin
					st_next = seg_bad ? S_SKIP : S_SEG_DATA;
				end
			end
			S_SEG_DATA: begin
				if (take && buf_full) begin
					st_next = S_SKIP;
				end
			end
			S_ARG: begin
				if (take) begin
					st_next = S_KEY;
				end
			end
			S_DRAIN: begin
				if (drain_end) begin
					st_next = S_KEY;
				end
			end
			S_PASS, S_SKIP: st_next = st_reg;
			default: st_next = S_KEY;
		endcase
		if (take && link.dn_last) begin
			st_next = S_KEY;
			if ((st_reg == S_SEG_CNT && !seg_bad &&
				d == tslp_pkg::FINAL_SEG_COUNT) ||
				(st_reg == S_SEG_DATA && !buf_full &&
				seg_cnt_reg == tslp_pkg::FINAL_SEG_COUNT)) begin
				st_next = S_DRAIN;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= S_KEY;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// segment bookkeeping
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_sub_reg <= 1'b0;
			seg_active_reg <= 1'b0;
			seg_cnt_reg <= 8'h00;
			wptr_reg <= '0;
			seq_error_reg <= 1'b0;
		end else if (sl_reset) begin
			seg_active_reg <= 1'b0;
			wptr_reg <= '0;
			seq_error_reg <= 1'b0;
		end else if (take && st_reg == S_KEY) begin
			seg_sub_reg <= (d == tslp_pkg::KW_SEG_SUB);
		end else if (take && st_reg == S_SEG_CNT) begin
			if (seg_bad) begin
				seq_error_reg <= 1'b1;
				seg_active_reg <= 1'b0;
				wptr_reg <= '0;
			end else begin
				seg_cnt_reg <= d;
				seg_active_reg <= 1'b1;
				if (!seg_sub_reg) begin
					wptr_reg <= '0;
				end
			end
		end else if (take && st_reg == S_SEG_DATA) begin
			if (buf_full) begin
				seq_error_reg <= 1'b1;
				seg_active_reg <= 1'b0;
				wptr_reg <= '0;
			end else begin
				wptr_reg <= wptr_reg + 1'b1;
			end
		end else if (st_reg == S_DRAIN && drain_end) begin
			seg_active_reg <= 1'b0;
			wptr_reg <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (take && st_reg == S_SEG_DATA && !buf_full) begin
			seg_mem[wptr_reg[PTR_W-2:0]] <= d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rptr_reg <= '0;
		end else if (st_reg == S_DRAIN && !drain_end) begin
			rptr_reg <= rptr_reg + 1'b1;
		end else begin
			rptr_reg <= '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_cnt_reg <= 8'h00;
		end else if (take && st_reg == S_BLK_CNT) begin
			blk_cnt_reg <= d;
		end else if (take && st_reg == S_BLK_DATA) begin
			blk_cnt_reg <= blk_cnt_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// forwarding to the virtual machines
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= 8'h00;
			out_last <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			if (take && ((st_reg == S_KEY && st_next == S_PASS) ||
				(st_reg == S_KEY && st_next == S_KEY &&
				!(d inside {tslp_pkg::KW_SL_RESET, tslp_pkg::KW_BLOCK,
				tslp_pkg::KW_SEG_INIT, tslp_pkg::KW_SEG_SUB})) ||
				st_reg == S_PASS)) begin
				out_valid <= 1'b1;
				out_data <= d;
				out_last <= link.dn_last;
			end else if (take && st_reg == S_BLK_DATA) begin
				out_valid <= 1'b1;
				out_data <= d;
				out_last <= (blk_cnt_reg == 8'h01) || link.dn_last;
			end else if (st_reg == S_DRAIN && wptr_reg != '0) begin
				out_valid <= 1'b1;
				out_data <= seg_mem[rptr_reg[PTR_W-2:0]];
				out_last <= drain_end;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// logical switch and groups
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= 8'h00;
			sel_vm_reg <= VM_W'(tslp_pkg::RESET_VM);
			group_mode_reg <= 1'b0;
			group_mask_reg <= '0;
		end else if (sl_reset) begin
			sel_vm_reg <= VM_W'(tslp_pkg::RESET_VM);
			group_mode_reg <= 1'b0;
			group_mask_reg <= '0;
		end else if (take && st_reg == S_KEY) begin
			cmd_reg <= d;
		end else if (take && st_reg == S_ARG) begin
			case (cmd_reg)
				tslp_pkg::KW_VM_SELECT: begin
					sel_vm_reg <= d[VM_W-1:0];
					group_mode_reg <= 1'b0;
				end
				tslp_pkg::KW_GRP_ASSIGN: group_mask_reg[d[VM_W-1:0]] <= 1'b1;
				tslp_pkg::KW_GRP_DEASSIGN: group_mask_reg[d[VM_W-1:0]] <= 1'b0;
				tslp_pkg::KW_GRP_SELECT: group_mode_reg <= 1'b1;
				default: group_mode_reg <= group_mode_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reverse route: select message goes out ahead of a new machine's traffic
	assign link.up_valid = (tx_st_reg == T_SEL_KEY) ||
		(tx_st_reg == T_SEL_ARG) || (tx_st_reg == T_MSG && vm_tx_valid);
	assign link.up_data = (tx_st_reg == T_SEL_KEY) ? tslp_pkg::KW_VM_SELECT :
		(tx_st_reg == T_SEL_ARG) ? 8'(rev_vm_reg) : vm_tx_data;
	assign link.up_last = (tx_st_reg == T_SEL_ARG) ||
		(tx_st_reg == T_MSG && vm_tx_last);
	assign vm_tx_ready = (tx_st_reg == T_MSG) && link.up_ready;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_reg <= T_IDLE;
			rev_vm_reg <= VM_W'(tslp_pkg::RESET_VM);
			rev_valid_reg <= 1'b0;
		end else begin
			case (tx_st_reg)
				T_IDLE: begin
					if (vm_tx_valid) begin
						if (!rev_valid_reg || vm_tx_vm != rev_vm_reg) begin
							rev_vm_reg <= vm_tx_vm;
							rev_valid_reg <= 1'b1;
							tx_st_reg <= T_SEL_KEY;
						end else begin
							tx_st_reg <= T_MSG;
						end
					end
				end
				T_SEL_KEY: begin
					if (link.up_ready) begin
						tx_st_reg <= T_SEL_ARG;
					end
				end
				T_SEL_ARG: begin
					if (link.up_ready) begin
						tx_st_reg <= T_MSG;
					end
				end
				T_MSG: begin
					if (vm_tx_valid && link.up_ready && vm_tx_last) begin
						tx_st_reg <= T_IDLE;
					end
				end
				default: tx_st_reg <= T_IDLE;
			endcase
		end
	end

endmodule // tslp_trib

// ---- tslp_link_monitor.sv ----
// link checker for the controller-to-tributary byte link
// assumes both ends share core_clk and rst_n, signals taken from the link
`timescale 1ns/1ps
module tslp_link_monitor (
	input logic core_clk,
	input logic rst_n,
	input logic dn_valid,
	input logic dn_ready,
	input logic [7:0] dn_data,
	input logic dn_last,
	input logic up_valid,
	input logic up_ready,
	input logic [7:0] up_data,
	input logic up_last
);
	////////////////////////////////////////////////////////////////////////
	// byte position inside each block, keyword and last segment count
	logic dn_tk, up_tk, dn_seg;
	logic [8:0] dn_pos_reg, up_pos_reg;
	logic [7:0] dn_kw_reg, cnt_reg;
	assign dn_tk = dn_valid && dn_ready;
	assign up_tk = up_valid && up_ready;
	assign dn_seg = dn_kw_reg == tslp_pkg::KW_SEG_INIT ||
		dn_kw_reg == tslp_pkg::KW_SEG_SUB;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			dn_pos_reg <= '0;
		else if (dn_tk)
			dn_pos_reg <= dn_last ? 9'h000 : dn_pos_reg + 9'h001;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			up_pos_reg <= '0;
		else if (up_tk)
			up_pos_reg <= up_last ? 9'h000 : up_pos_reg + 9'h001;
	end
	// count is kept across blocks so the next segment can be judged
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dn_kw_reg <= '0;
			cnt_reg <= '0;
		end else if (dn_tk && dn_pos_reg == 9'h000) begin
			dn_kw_reg <= dn_data;
		end else if (dn_tk && dn_pos_reg == 9'h001 && dn_seg) begin
			cnt_reg <= dn_data;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence dn_sel_head;
		dn_tk && dn_pos_reg == 9'h000 && dn_data == tslp_pkg::KW_VM_SELECT;
	endsequence
	sequence up_sel_head;
		up_tk && up_pos_reg == 9'h000 && up_data == tslp_pkg::KW_VM_SELECT;
	endsequence
	a_dn_hold: assert property (dn_valid && !dn_ready |=>
		dn_valid && $stable(dn_data) && $stable(dn_last))
		else $error("downstream byte changed while stalled");
	a_up_hold: assert property (up_valid && !up_ready |=>
		up_valid && $stable(up_data) && $stable(up_last))
		else $error("upstream byte changed while stalled");
	a_dn_sel_pair: assert property (dn_sel_head |=>
		dn_valid && dn_last)
		else $error("select block not two bytes");
	a_up_sel_pair: assert property (up_sel_head |=>
		up_valid && up_last)
		else $error("reverse select block not two bytes");
	a_seg_descend: assert property (dn_tk && dn_pos_reg == 9'h001 &&
		dn_kw_reg == tslp_pkg::KW_SEG_SUB |-> dn_data == cnt_reg - 8'h01)
		else $error("segment count not descending by one");
	a_seg_opens: assert property (dn_tk && dn_pos_reg == 9'h000 &&
		dn_data == tslp_pkg::KW_SEG_SUB |-> cnt_reg != 8'h00)
		else $error("subsequent segment without open sequence");
	a_drain_stall: assert property (dn_tk && dn_last && dn_seg &&
		dn_pos_reg > 9'h001 && cnt_reg == 8'h00 |-> ##[1:2] !dn_ready)
		else $error("no drain after final segment");
	a_dn_blk_len: assert property (dn_tk |-> dn_pos_reg < 9'h100)
		else $error("downstream block over 256 bytes");
	a_up_blk_len: assert property (up_tk |-> up_pos_reg < 9'h100)
		else $error("upstream block over 256 bytes");
endmodule // tslp_link_monitor

// ---- tributary_service_level_parser_tb_top.sv ----
// bench: controller and tributary joined by one link, a second tributary
// driven byte by byte to break segment rules on purpose
`timescale 1ns/1ps
module tributary_service_level_parser_tb_top;
	logic core_clk, rst_n, msg_valid, msg_ready, msg_last, cmd_valid;
	logic cmd_ready, rx_valid, rx_last, out_valid, out_last, seq_error;
	logic vm_tx_valid, vm_tx_ready, vm_tx_last, o2_valid, o2_last, err2;
	logic [3:0] msg_vm, rx_vm, selected_vm, vm_tx_vm, sel2;
	logic [15:0] msg_len, out_vm_mask, mask2;
	logic [7:0] msg_data, cmd_code, cmd_arg, rx_data, out_data, vm_tx_data;
	logic [7:0] o2_data;
	logic [8:0] q1[$], q2[$], qr[$];
	int miscompares = 0;
	int n_tests = 0;
	tslp_link_if link1();
	tslp_link_if link2();
	assign link2.up_ready = 1'b1;
	tslp_ctrl tslp_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n),
		.link(link1), .msg_valid(msg_valid), .msg_ready(msg_ready),
		.msg_vm(msg_vm), .msg_len(msg_len), .msg_data(msg_data),
		.msg_last(msg_last), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_arg(cmd_arg), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_vm(rx_vm));
	tslp_trib tslp_trib_inst (.core_clk(core_clk), .rst_n(rst_n),
		.link(link1), .out_valid(out_valid), .out_data(out_data),
		.out_last(out_last), .out_vm_mask(out_vm_mask),
		.selected_vm(selected_vm), .seq_error(seq_error),
		.vm_tx_valid(vm_tx_valid), .vm_tx_ready(vm_tx_ready),
		.vm_tx_vm(vm_tx_vm), .vm_tx_data(vm_tx_data), .vm_tx_last(vm_tx_last));
	tslp_trib tslp_trib2_inst (.core_clk(core_clk), .rst_n(rst_n),
		.link(link2), .out_valid(o2_valid), .out_data(o2_data),
		.out_last(o2_last), .out_vm_mask(mask2), .selected_vm(sel2),
		.seq_error(err2), .vm_tx_valid(1'b0), .vm_tx_ready(),
		.vm_tx_vm(4'h0), .vm_tx_data(8'h00), .vm_tx_last(1'b0));
	tslp_link_monitor tslp_link_monitor_inst (.core_clk(core_clk),
		.rst_n(rst_n), .dn_valid(link1.dn_valid), .dn_ready(link1.dn_ready),
		.dn_data(link1.dn_data), .dn_last(link1.dn_last),
		.up_valid(link1.up_valid), .up_ready(link1.up_ready),
		.up_data(link1.up_data), .up_last(link1.up_last));
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// outputs are sampled before the edge's own updates land
	always @(posedge core_clk) begin
		if (out_valid === 1'b1) q1.push_back({out_last, out_data});
		if (o2_valid === 1'b1) q2.push_back({o2_last, o2_data});
		if (rx_valid === 1'b1) qr.push_back({rx_last, rx_data});
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_q(ref logic [8:0] q[$], input int n,
		input logic [7:0] base);
		int w = 0;
		while (q.size() < n && w < 3000) begin
			@(posedge core_clk);
			w++;
		end
		repeat (4) @(posedge core_clk);
		chk(16'(q.size()), 16'(n));
		for (int i = 0; i < n && i < q.size(); i++)
			chk({7'h00, q[i]}, {7'h00, i == n - 1, base + 8'(i)});
		q.delete();
	endtask
	// waits for the chosen ready, bounded so a stuck handshake still ends
	task automatic hs(input int sel);
		int n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (((sel == 0) ? msg_ready : (sel == 1) ? cmd_ready :
			(sel == 2) ? vm_tx_ready : link2.dn_ready) !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			miscompares++;
			$display("CHECK FAILED t=%0t handshake stuck", $time);
		end
	endtask
	task automatic send_msg(input logic [3:0] vm, input int len,
		input logic [7:0] base);
		for (int i = 0; i < len; i++) begin
			msg_valid <= 1'b1;
			msg_vm <= vm;
			msg_len <= 16'(len);
			msg_data <= base + 8'(i);
			msg_last <= i == len - 1;
			hs(0);
		end
		msg_valid <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic send_cmd(input logic [7:0] code, input logic [7:0] arg);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_arg <= arg;
		hs(1);
		cmd_valid <= 1'b0;
		hs(1);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic send_vm(input logic [3:0] vm, input int len,
		input logic [7:0] base);
		for (int i = 0; i < len; i++) begin
			vm_tx_valid <= 1'b1;
			vm_tx_vm <= vm;
			vm_tx_data <= base + 8'(i);
			vm_tx_last <= i == len - 1;
			hs(2);
		end
		vm_tx_valid <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic blk2(input logic [7:0] b[$]);
		foreach (b[i]) begin
			link2.dn_valid <= 1'b1;
			link2.dn_data <= b[i];
			link2.dn_last <= i == b.size() - 1;
			hs(3);
		end
		link2.dn_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		rst_n = 1'b0;
		{msg_valid, msg_last, cmd_valid, vm_tx_valid, vm_tx_last} = '0;
		{msg_vm, vm_tx_vm, msg_len, msg_data, cmd_code, cmd_arg} = '0;
		vm_tx_data = 8'h00;
		{link2.dn_valid, link2.dn_data, link2.dn_last} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk(16'(selected_vm), 16'h0000);
		chk(out_vm_mask, 16'h0001);
		send_msg(4'h2, 3, 8'h10);
		chk_q(q1, 3, 8'h10);
		chk(16'(selected_vm), 16'h0002);
		$display("test raw done");
		send_msg(4'h2, 260, 8'h20);
		// a command queued behind the drain must wait on the stalled link
		send_cmd(tslp_pkg::KW_GRP_ASSIGN, 8'h01);
		chk_q(q1, 260, 8'h20);
		chk(16'(selected_vm), 16'h0002);
		$display("test segments done");
		send_cmd(tslp_pkg::KW_GRP_ASSIGN, 8'h03);
		send_cmd(tslp_pkg::KW_GRP_SELECT, 8'h00);
		chk(out_vm_mask, 16'h000a);
		send_cmd(tslp_pkg::KW_GRP_DEASSIGN, 8'h03);
		chk(out_vm_mask, 16'h0002);
		send_cmd(tslp_pkg::KW_SL_RESET, 8'h00);
		chk(16'(selected_vm), 16'h0000);
		chk(out_vm_mask, 16'h0001);
		send_msg(4'h6, 2, 8'h50);
		chk_q(q1, 2, 8'h50);
		chk(16'(selected_vm), 16'h0006);
		$display("test groups done");
		send_vm(4'h5, 2, 8'h30);
		chk_q(qr, 2, 8'h30);
		chk(16'(rx_vm), 16'h0005);
		$display("test reverse done");
		blk2('{tslp_pkg::KW_VM_SELECT, 8'h07});
		chk(16'(sel2), 16'h0007);
		chk(mask2, 16'h0080);
		blk2('{tslp_pkg::KW_BLOCK, 8'h02, 8'h41, 8'h42});
		chk_q(q2, 2, 8'h41);
		blk2('{tslp_pkg::KW_SEG_SUB, 8'h00, 8'h55});
		chk(16'(err2), 16'h0001);
		blk2('{tslp_pkg::KW_SL_RESET});
		chk(16'(err2), 16'h0000);
		chk(16'(sel2), 16'h0000);
		blk2('{tslp_pkg::KW_SEG_INIT, 8'h02, 8'h61});
		blk2('{tslp_pkg::KW_SEG_SUB, 8'h00, 8'h62});
		chk(16'(err2), 16'h0001);
		chk(16'(q2.size()), 16'h0000);
		$display("test faults done");
		tally_and_finish;
	end
endmodule // tributary_service_level_parser_tb_top
